// ---- cfs_pkg.sv ----
// Constants and state types for the CAN receive queue status block
package cfs_pkg;

    // ==========================================================
    // Register map, byte addresses of aligned 32-bit words
    localparam logic [7:0] OFS_RXQ0 = 8'h00;
    localparam logic [7:0] OFS_RXQ1 = 8'h04;
    localparam logic [7:0] OFS_IRQ_STS = 8'h08;
    localparam logic [7:0] OFS_IRQ_MSK = 8'h0c;
    localparam logic [7:0] OFS_SLOTS = 8'h10;

    // ==========================================================
    // Queue status register fields
    localparam int unsigned FLD_RELEASE = 5;
    localparam int unsigned FLD_OVERRUN = 4;
    localparam int unsigned FLD_FULL = 3;
    localparam int unsigned FLD_COUNT = 0;

    // ==========================================================
    // Interrupt status and mask fields, one nibble per queue
    localparam int unsigned IRQ_STRIDE = 4;
    localparam int unsigned IRQ_MSG = 0;
    localparam int unsigned IRQ_FULL = 1;
    localparam int unsigned IRQ_OVR = 2;
    localparam logic [7:0] IRQ_USED = 8'h77;

    // ==========================================================
    // Slot pointer register fields, one byte per queue
    localparam int unsigned SLOT_STRIDE = 8;
    localparam int unsigned SLOT_RD = 0;
    localparam int unsigned SLOT_WR = 2;

    // ==========================================================
    // Depth and reset values
    localparam logic [1:0] Q_DEPTH = 2'h3;
    localparam logic [1:0] Q_LAST_SLOT = 2'h2;
    localparam logic [1:0] RST_COUNT = 2'h0;
    localparam logic [1:0] RST_SLOT = 2'h0;
    localparam logic RST_FLAG = 1'h0;
    localparam logic [7:0] RST_IRQ = 8'h00;
    localparam logic [31:0] RST_RDATA = 32'h0000_0000;

    // ==========================================================
    // State of one receive queue
    typedef struct packed {
        logic [1:0] count;
        logic full;
        logic overrun;
        logic release_pend;
        logic [1:0] rd_slot;
        logic [1:0] wr_slot;
    } cfs_queue_st_t;

    // State of the register front end
    typedef struct packed {
        logic [7:0] irq_sts;
        logic [7:0] irq_msk;
        logic [31:0] rdata;
    } cfs_top_st_t;

endpackage : cfs_pkg

// ---- cfs_queue.sv ----
// Status keeping for one three-deep receive queue
`timescale 1ns/10ps
module cfs_queue (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic accept,
    input wire logic release_wr,
    input wire logic clr_full,
    input wire logic clr_overrun,
    output logic [1:0] count,
    output logic full,
    output logic overrun,
    output logic release_pend,
    output logic [1:0] rd_slot,
    output logic [1:0] wr_slot,
    output logic ev_msg,
    output logic ev_full
);
    cfs_pkg::cfs_queue_st_t st_reg;
    cfs_pkg::cfs_queue_st_t st_next;
    logic push;
    logic pop;
    logic [1:0] cnt_after_pop;

    // Next state of the queue
    always_comb begin
        st_next = st_reg;
        pop = st_reg.release_pend; // R1 R7
        push = accept && ((st_reg.count != cfs_pkg::Q_DEPTH) || pop); // R6 R12 R16
        cnt_after_pop = st_reg.count - {1'h0, pop};
        // Pending count, unchanged when push and pop meet
        if (push && !pop) begin
            st_next.count = st_reg.count + 2'h1; // R6 R12
        end else if (pop && !push) begin
            st_next.count = cnt_after_pop; // R7 R12
        end // R17
        // Release is only taken while a message remains
        st_next.release_pend = release_wr && (cnt_after_pop != 2'h0); // R1 R2 R9
        // Read-out slot moves past the released message
        if (pop) begin
            st_next.rd_slot = (st_reg.rd_slot == cfs_pkg::Q_LAST_SLOT) ? 2'h0 : st_reg.rd_slot + 2'h1; // R16
        end
        if (push) begin
            st_next.wr_slot = (st_reg.wr_slot == cfs_pkg::Q_LAST_SLOT) ? 2'h0 : st_reg.wr_slot + 2'h1;
        end
        // Sticky flags, a hardware set beats a software clear
        if (clr_full) begin
            st_next.full = 1'h0; // R4 R11
        end
        if (push && (st_next.count == cfs_pkg::Q_DEPTH)) begin
            st_next.full = 1'h1; // R4 R11
        end
        if (clr_overrun) begin
            st_next.overrun = 1'h0; // R3 R10
        end
        if (accept && !push) begin
            st_next.overrun = 1'h1; // R3 R10 R16
        end
    end

    // State register
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            st_reg <= '{count: cfs_pkg::RST_COUNT, full: cfs_pkg::RST_FLAG, overrun: cfs_pkg::RST_FLAG,
                        release_pend: cfs_pkg::RST_FLAG, rd_slot: cfs_pkg::RST_SLOT, wr_slot: cfs_pkg::RST_SLOT};
        end else begin
            st_reg <= st_next;
        end
    end

    // Status outputs from the state register, event strobes from the next-state logic
    assign count = st_reg.count;
    assign full = st_reg.full;
    assign overrun = st_reg.overrun;
    assign release_pend = st_reg.release_pend;
    assign rd_slot = st_reg.rd_slot;
    assign wr_slot = st_reg.wr_slot;
    assign ev_msg = push;
    assign ev_full = push && (st_next.count == cfs_pkg::Q_DEPTH);

endmodule : cfs_queue

// ---- cfs_top.sv ----
// Register front end and interrupt logic for the two CAN receive queues
//
// What this block does
// (R1) Writing one sets queue 0 release; hardware clears it once the message is released.
// (R2) A release write to an empty queue 0 changes nothing.
// (R3) Queue 0 overrun sets when a filtered message meets a full queue; write one clears.
// (R4) Queue 0 full sets at three pending messages; stays until software writes one.
// (R5) Queue 0 pending count is a two-bit read-only field; writes ignored.
// (R6) Queue 0 count rises by one per filtered message accepted while not full.
// (R7) Queue 0 count falls by one per software release.
// (R8) Software releases queue 0 after reading to reach the next message.
// (R9) Queue 1 release bit set by software, cleared by hardware, ignored when empty.
// (R10) Queue 1 overrun sets on a filtered message while full; write one clears.
// (R11) Queue 1 full sets at three pending messages; write one clears.
// (R12) Queue 1 count rises on each accepted message, falls on each release.
// (R13) Software releases queue 1 after reading to reach the next message.
// (R14) Unused bits of both queue registers read zero; software writes zero.
// (R15) Queue 1 overrun interrupt only when its flag and its enable are both set.
// (R16) Each queue shows its oldest message slot; release advances; full drops arrivals.
// (R17) Accept and release in the same cycle leave the count unchanged.
`timescale 1ns/10ps
module cfs_top (
    input wire logic REF_CLK,
    input wire logic RSTN,
    input wire logic [7:0] ADDR,
    input wire logic [31:0] WDATA,
    input wire logic WR,
    input wire logic RD,
    output logic [31:0] RDATA,
    input wire logic ACCEPT0,
    input wire logic ACCEPT1,
    output logic [1:0] Q0_RD_SLOT,
    output logic [1:0] Q0_WR_SLOT,
    output logic [1:0] Q1_RD_SLOT,
    output logic [1:0] Q1_WR_SLOT,
    output logic IRQ
);

    // ==========================================================
    // Declarations
    // ==========================================================

    // Front end state and its next value
    cfs_pkg::cfs_top_st_t st_reg;
    cfs_pkg::cfs_top_st_t st_next;

    // Per queue strobes toward the queue trackers
    logic [1:0] accept_vec;
    logic [1:0] release_wr;
    logic [1:0] clr_full;
    logic [1:0] clr_overrun;

    // Per queue state coming back from the trackers
    logic [1:0][1:0] q_count;
    logic [1:0] q_full;
    logic [1:0] q_overrun;
    logic [1:0] q_release;
    logic [1:0][1:0] q_rd_slot;
    logic [1:0][1:0] q_wr_slot;
    logic [1:0] q_ev_msg;
    logic [1:0] q_ev_full;

    // Register views assembled for read-back
    logic [1:0][31:0] q_reg_view;
    logic [7:0] irq_view;
    logic [31:0] slot_view;

    // Address decode of the write strobe
    logic wr_q0;
    logic wr_q1;
    logic wr_sts;
    logic wr_msk;

    // Clear pattern written to the interrupt status
    logic [7:0] sts_clr;

    // Sticky event bits that live in the front end
    logic [7:0] sts_set;

    // ==========================================================
    // Write decode
    // ==========================================================

    // One strobe per writable register, only on an exact aligned address
    assign wr_q0 = WR && (ADDR == cfs_pkg::OFS_RXQ0);
    assign wr_q1 = WR && (ADDR == cfs_pkg::OFS_RXQ1);
    assign wr_sts = WR && (ADDR == cfs_pkg::OFS_IRQ_STS);
    assign wr_msk = WR && (ADDR == cfs_pkg::OFS_IRQ_MSK);

    // Ones written to the status register clear the matching bits
    assign sts_clr = wr_sts ? (WDATA[7:0] & cfs_pkg::IRQ_USED) : 8'h00;

    // Filter strobes arrive from logic on this clock, used directly
    assign accept_vec = {ACCEPT1, ACCEPT0};

    // ==========================================================
    // Queue trackers
    // ==========================================================

    genvar gq;
    generate
        for (gq = 0; gq < 2; gq++) begin : g_queue
            logic wr_this;

            // Queue register write strobe for this queue
            assign wr_this = (gq == 0) ? wr_q0 : wr_q1;

            // Release request, only bit 5 of the data counts
            assign release_wr[gq] = wr_this && WDATA[cfs_pkg::FLD_RELEASE]; // R1 R9

            // Full flag clears from its own register or from the status view
            assign clr_full[gq] = (wr_this && WDATA[cfs_pkg::FLD_FULL]) ||
                                  sts_clr[gq * cfs_pkg::IRQ_STRIDE + cfs_pkg::IRQ_FULL]; // R4 R11

            // Overrun flag clears the same two ways
            assign clr_overrun[gq] = (wr_this && WDATA[cfs_pkg::FLD_OVERRUN]) ||
                                     sts_clr[gq * cfs_pkg::IRQ_STRIDE + cfs_pkg::IRQ_OVR]; // R3 R10

            // Count, flags and slot pointers of one queue
            cfs_queue u_queue (
                .clk(REF_CLK),
                .rst_n(RSTN),
                .accept(accept_vec[gq]),
                .release_wr(release_wr[gq]),
                .clr_full(clr_full[gq]),
                .clr_overrun(clr_overrun[gq]),
                .count(q_count[gq]),
                .full(q_full[gq]),
                .overrun(q_overrun[gq]),
                .release_pend(q_release[gq]),
                .rd_slot(q_rd_slot[gq]),
                .wr_slot(q_wr_slot[gq]),
                .ev_msg(q_ev_msg[gq]),
                .ev_full(q_ev_full[gq])
            );

            // Queue register as software sees it, unused bits zero
            always_comb begin
                q_reg_view[gq] = 32'h0000_0000; // R14
                q_reg_view[gq][cfs_pkg::FLD_RELEASE] = q_release[gq];
                q_reg_view[gq][cfs_pkg::FLD_OVERRUN] = q_overrun[gq];
                q_reg_view[gq][cfs_pkg::FLD_FULL] = q_full[gq];
                q_reg_view[gq][cfs_pkg::FLD_COUNT +: 2] = q_count[gq]; // R5 R12
            end

            // Message arrival sets a sticky status bit
            always_comb begin
                sts_set[gq * cfs_pkg::IRQ_STRIDE + cfs_pkg::IRQ_MSG] = q_ev_msg[gq];
                sts_set[gq * cfs_pkg::IRQ_STRIDE + cfs_pkg::IRQ_FULL] = q_ev_full[gq];
                sts_set[gq * cfs_pkg::IRQ_STRIDE + cfs_pkg::IRQ_OVR] = 1'h0;
                sts_set[gq * cfs_pkg::IRQ_STRIDE + 3] = 1'h0;
            end

            // Interrupt status view, full and overrun are the queue flags
            always_comb begin
                irq_view[gq * cfs_pkg::IRQ_STRIDE + cfs_pkg::IRQ_MSG] =
                    st_reg.irq_sts[gq * cfs_pkg::IRQ_STRIDE + cfs_pkg::IRQ_MSG];
                irq_view[gq * cfs_pkg::IRQ_STRIDE + cfs_pkg::IRQ_FULL] = q_full[gq];
                irq_view[gq * cfs_pkg::IRQ_STRIDE + cfs_pkg::IRQ_OVR] = q_overrun[gq]; // R15
                irq_view[gq * cfs_pkg::IRQ_STRIDE + 3] = 1'h0;
            end

            // Slot pointers for the mailbox read-out and fill logic
            always_comb begin
                slot_view[gq * cfs_pkg::SLOT_STRIDE +: cfs_pkg::SLOT_STRIDE] = 8'h00;
                slot_view[gq * cfs_pkg::SLOT_STRIDE + cfs_pkg::SLOT_RD +: 2] = q_rd_slot[gq]; // R16
                slot_view[gq * cfs_pkg::SLOT_STRIDE + cfs_pkg::SLOT_WR +: 2] = q_wr_slot[gq];
            end
        end
    endgenerate

    // Upper half of the slot register reads zero
    assign slot_view[31:16] = 16'h0000;

    // ==========================================================
    // Front end next state
    // ==========================================================

    // Read data, status and mask updates
    always_comb begin
        st_next = st_reg;
        // Read data stand only in the cycle after the strobe
        st_next.rdata = cfs_pkg::RST_RDATA;
        if (RD) begin
            case (ADDR)
                cfs_pkg::OFS_RXQ0: begin
                    st_next.rdata = q_reg_view[0]; // R5 R14
                end
                cfs_pkg::OFS_RXQ1: begin
                    st_next.rdata = q_reg_view[1]; // R12 R14
                end
                cfs_pkg::OFS_IRQ_STS: begin
                    st_next.rdata = {24'h00_0000, irq_view};
                end
                cfs_pkg::OFS_IRQ_MSK: begin
                    st_next.rdata = {24'h00_0000, st_reg.irq_msk};
                end
                cfs_pkg::OFS_SLOTS: begin
                    st_next.rdata = slot_view;
                end
                default: begin
                    st_next.rdata = cfs_pkg::RST_RDATA;
                end
            endcase
        end
        // Sticky status, a new event wins over a clear in the same cycle
        st_next.irq_sts = ((st_reg.irq_sts & ~sts_clr) | sts_set) & cfs_pkg::IRQ_USED;
        // Mask register, same layout as the status
        if (wr_msk) begin
            st_next.irq_msk = WDATA[7:0] & cfs_pkg::IRQ_USED;
        end
    end

    // ==========================================================
    // Front end state register
    // ==========================================================

    // Asynchronous reset to constants
    always_ff @(posedge REF_CLK or negedge RSTN) begin
        if (!RSTN) begin
            st_reg <= '{irq_sts: cfs_pkg::RST_IRQ, irq_msk: cfs_pkg::RST_IRQ, rdata: cfs_pkg::RST_RDATA};
        end else begin
            st_reg <= st_next;
        end
    end

    // ==========================================================
    // Outputs
    // ==========================================================

    // Read data straight from the register
    assign RDATA = st_reg.rdata;

    // Slot pointers toward the mailbox store
    assign Q0_RD_SLOT = q_rd_slot[0]; // R8 R16
    assign Q0_WR_SLOT = q_wr_slot[0];
    assign Q1_RD_SLOT = q_rd_slot[1]; // R13 R16
    assign Q1_WR_SLOT = q_wr_slot[1];

    // Level interrupt while any enabled flag stands
    assign IRQ = |(irq_view & st_reg.irq_msk); // R15

endmodule : cfs_top

// ---- cfs_props.sv ----
// Port-level assertions for the CAN receive queue status block
`timescale 1ns/10ps
module cfs_props (
    input wire logic REF_CLK,
    input wire logic RSTN,
    input wire logic [7:0] ADDR,
    input wire logic [31:0] WDATA,
    input wire logic WR,
    input wire logic RD,
    input wire logic [31:0] RDATA,
    input wire logic ACCEPT0,
    input wire logic ACCEPT1,
    input wire logic [1:0] Q0_RD_SLOT,
    input wire logic [1:0] Q0_WR_SLOT,
    input wire logic [1:0] Q1_RD_SLOT,
    input wire logic [1:0] Q1_WR_SLOT,
    input wire logic IRQ
);
    // ==========================================================
    // Shared clocking and reset
    default clocking cb @(posedge REF_CLK);
    endclocking
    default disable iff (!RSTN);

    // Slot ring of three entries
    function automatic logic [1:0] nxt(input logic [1:0] s);
        return (s == 2'h2) ? 2'h0 : s + 2'h1;
    endfunction : nxt

    // ==========================================================
    // Read data, reserved bits and slot read-out
    a_rdata_idle_zero: assert property (!$past(RD) |-> RDATA == 32'h0)
        else $error("read data not zero outside a read answer");
    a_reserved_bits_zero: assert property ($past(RD) && $past(ADDR[7:3]) == 5'h0 && $past(ADDR[1:0]) == 2'h0
        |-> RDATA[31:6] == 26'h0 && !RDATA[2])
        else $error("reserved queue register bits not zero");
    a_slot_read_match: assert property ($past(RD) && $past(ADDR) == cfs_pkg::OFS_SLOTS |-> RDATA ==
        {20'h0, $past(Q1_WR_SLOT), $past(Q1_RD_SLOT), 4'h0, $past(Q0_WR_SLOT), $past(Q0_RD_SLOT)})
        else $error("slot register differs from slot outputs");

    // ==========================================================
    // Slot movement tied to accepts and releases, interrupt off when all masked
    a_q0_wr_hold: assert property (!ACCEPT0 |=> $stable(Q0_WR_SLOT))
        else $error("queue 0 write slot moved without an accept");
    a_q1_wr_step: assert property (ACCEPT1
        |=> Q1_WR_SLOT == $past(Q1_WR_SLOT) || Q1_WR_SLOT == nxt($past(Q1_WR_SLOT)))
        else $error("queue 1 write slot moved by other than one");
    a_q0_rd_hold: assert property (!(WR && ADDR == cfs_pkg::OFS_RXQ0 && WDATA[5]) |-> ##2 $stable(Q0_RD_SLOT))
        else $error("queue 0 read slot moved without a release");
    a_q1_rd_step: assert property (WR && ADDR == cfs_pkg::OFS_RXQ1 && WDATA[5]
        |-> ##2 (Q1_RD_SLOT == $past(Q1_RD_SLOT) || Q1_RD_SLOT == nxt($past(Q1_RD_SLOT))))
        else $error("queue 1 read slot moved by other than one");
    a_irq_mask_off: assert property (WR && ADDR == cfs_pkg::OFS_IRQ_MSK && WDATA[7:0] == 8'h00 |=> !IRQ)
        else $error("interrupt high with all sources masked");
endmodule : cfs_props

bind cfs_top cfs_props u_props (.REF_CLK(REF_CLK), .RSTN(RSTN), .ADDR(ADDR), .WDATA(WDATA), .WR(WR), .RD(RD),
    .RDATA(RDATA), .ACCEPT0(ACCEPT0), .ACCEPT1(ACCEPT1), .Q0_RD_SLOT(Q0_RD_SLOT), .Q0_WR_SLOT(Q0_WR_SLOT),
    .Q1_RD_SLOT(Q1_RD_SLOT), .Q1_WR_SLOT(Q1_WR_SLOT), .IRQ(IRQ));

// ---- cfs_rx_model.sv ----
// Behavioural CAN receive path handing filtered messages to the queues
`timescale 1ns/10ps
module cfs_rx_model (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic [1:0] rate0,
    input wire logic [1:0] rate1,
    output logic accept0,
    output logic accept1
);
    // Rate 0 silent, 1 every cycle, 2 about one cycle in four
    function automatic logic fire(input logic [1:0] r);
        return r == 2'h1 || (r == 2'h2 && $urandom_range(3) == 0);
    endfunction : fire

    // At most one filtered message per queue and cycle
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            accept0 <= 1'b0;
            accept1 <= 1'b0;
        end else begin
            accept0 <= fire(rate0);
            accept1 <= fire(rate1);
        end
    end
endmodule : cfs_rx_model

// ---- tb_top.sv ----
// Self-checking bench for the CAN receive queue status block
`timescale 1ns/10ps
module tb_top;
    logic REF_CLK = 1'b0;
    logic RSTN = 1'b0;
    logic [7:0] ADDR = 8'h00;
    logic [31:0] WDATA = 32'h0;
    logic WR = 1'b0;
    logic RD = 1'b0;
    logic [1:0] rate0 = 2'h0;
    logic [1:0] rate1 = 2'h0;
    logic [31:0] RDATA;
    logic ACCEPT0, ACCEPT1, IRQ;
    logic [1:0] Q0_RD_SLOT, Q0_WR_SLOT, Q1_RD_SLOT, Q1_WR_SLOT;
    int err_count = 0;
    int comparisons = 0;
    int unsigned seed;
    int unsigned k;
    logic [7:0] qa;
    logic [7:0] adrs [7] = '{cfs_pkg::OFS_RXQ0, cfs_pkg::OFS_RXQ1, cfs_pkg::OFS_SLOTS, 8'h14, 8'h02,
        cfs_pkg::OFS_IRQ_MSK, cfs_pkg::OFS_IRQ_STS};
    logic [1:0] cnt [2];
    logic [1:0] rds [2];
    logic [1:0] wrs [2];
    logic pend [2];
    logic ovr [2];
    logic full [2];
    logic msg [2];
    logic [7:0] slot_pins;
    logic [7:0] msk;
    logic [31:0] exp_rdata;

    // Free-running 100 MHz clock
    always #5 REF_CLK = ~REF_CLK;

    cfs_top dut (.REF_CLK(REF_CLK), .RSTN(RSTN), .ADDR(ADDR), .WDATA(WDATA), .WR(WR), .RD(RD), .RDATA(RDATA),
        .ACCEPT0(ACCEPT0), .ACCEPT1(ACCEPT1), .Q0_RD_SLOT(Q0_RD_SLOT), .Q0_WR_SLOT(Q0_WR_SLOT),
        .Q1_RD_SLOT(Q1_RD_SLOT), .Q1_WR_SLOT(Q1_WR_SLOT), .IRQ(IRQ));
    cfs_rx_model u_rx (.clk(REF_CLK), .rst_n(RSTN), .rate0(rate0), .rate1(rate1), .accept0(ACCEPT0),
        .accept1(ACCEPT1));

    // Slot outputs gathered for one compare
    assign slot_pins = {Q1_WR_SLOT, Q1_RD_SLOT, Q0_WR_SLOT, Q0_RD_SLOT};

    // ==========================================================
    // Expectation helpers
    function automatic logic [1:0] nxt(input logic [1:0] s);
        return (s == cfs_pkg::Q_LAST_SLOT) ? 2'h0 : s + 2'h1;
    endfunction : nxt
    function automatic logic [31:0] stat(input int q);
        return {26'h0, pend[q], ovr[q], full[q], 1'b0, cnt[q]};
    endfunction : stat
    function automatic logic [7:0] sts_view();
        return {1'b0, ovr[1], full[1], msg[1], 1'b0, ovr[0], full[0], msg[0]};
    endfunction : sts_view
    function automatic logic exp_irq();
        return |(sts_view() & msk & 8'h77);
    endfunction : exp_irq
    function automatic logic [31:0] rd_val(input logic [7:0] a);
        case (a)
            cfs_pkg::OFS_RXQ0: return stat(0);
            cfs_pkg::OFS_RXQ1: return stat(1);
            cfs_pkg::OFS_SLOTS: return {20'h0, wrs[1], rds[1], 4'h0, wrs[0], rds[0]};
            cfs_pkg::OFS_IRQ_STS: return {24'h0, sts_view()};
            cfs_pkg::OFS_IRQ_MSK: return {24'h0, msk & 8'h77};
            default: return 32'h0;
        endcase
    endfunction : rd_val

    // Reference queues, updated from the same inputs the design samples
    always @(posedge REF_CLK or negedge RSTN) begin : ref_model
        logic [1:0] c;
        logic acc;
        logic w;
        logic s;
        if (!RSTN) begin
            msg = '{default: 1'b0};
            cnt = '{default: 2'h0};
            rds = '{default: 2'h0};
            wrs = '{default: 2'h0};
            pend = '{default: 1'b0};
            ovr = '{default: 1'b0};
            full = '{default: 1'b0};
            msk = 8'h00;
            exp_rdata = 32'h0;
        end else begin
            exp_rdata = RD ? rd_val(ADDR) : 32'h0;
            if (WR && ADDR == cfs_pkg::OFS_IRQ_MSK) msk = WDATA[7:0];
            for (int q = 0; q < 2; q++) begin
                acc = q ? ACCEPT1 : ACCEPT0;
                w = WR && ADDR == (q ? cfs_pkg::OFS_RXQ1 : cfs_pkg::OFS_RXQ0);
                s = WR && ADDR == cfs_pkg::OFS_IRQ_STS;
                c = cnt[q] - {1'b0, pend[q]};
                if (pend[q]) rds[q] = nxt(rds[q]);
                if ((w && WDATA[cfs_pkg::FLD_OVERRUN]) || (s && WDATA[q * cfs_pkg::IRQ_STRIDE + cfs_pkg::IRQ_OVR]))
                    ovr[q] = 1'b0;
                if ((w && WDATA[cfs_pkg::FLD_FULL]) || (s && WDATA[q * cfs_pkg::IRQ_STRIDE + cfs_pkg::IRQ_FULL]))
                    full[q] = 1'b0;
                if (s && WDATA[q * cfs_pkg::IRQ_STRIDE + cfs_pkg::IRQ_MSG]) msg[q] = 1'b0;
                pend[q] = w && WDATA[cfs_pkg::FLD_RELEASE] && c != 2'h0;
                if (acc && c == cfs_pkg::Q_DEPTH) ovr[q] = 1'b1;
                if (acc && c != cfs_pkg::Q_DEPTH) begin
                    c = c + 2'h1;
                    wrs[q] = nxt(wrs[q]);
                    msg[q] = 1'b1;
                    full[q] = full[q] | (c == cfs_pkg::Q_DEPTH);
                end
                cnt[q] = c;
            end
        end
    end

    // ==========================================================
    // Comparison, bus and closing tasks
    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        comparisons++;
        if (g !== e) begin
            err_count++;
            $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
        end
    endtask : chk
    task automatic bus(input logic w, input logic r, input logic [7:0] a, input logic [31:0] d);
        WR <= w;
        RD <= r;
        ADDR <= a;
        WDATA <= d;
        @(posedge REF_CLK);
    endtask : bus
    task automatic tally_and_finish();
        if (err_count == 0 && comparisons > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask : tally_and_finish

    // Outputs checked every cycle where they have settled
    always @(negedge REF_CLK) begin
        chk("RDATA", exp_rdata, RDATA);
        chk("SLOTS", {24'h0, wrs[1], rds[1], wrs[0], rds[0]}, {24'h0, slot_pins});
        chk("IRQ", {31'h0, exp_irq()}, {31'h0, IRQ});
    end

    // Hang guard
    initial begin
        repeat (100000) @(posedge REF_CLK);
        err_count++;
        tally_and_finish();
    end

    // Directed pass per queue, then random traffic with a reset in mid-run
    initial begin
        seed = $urandom(32'hd14f);
        repeat (6) @(posedge REF_CLK);
        RSTN <= 1'b1;
        @(posedge REF_CLK);
        for (int q = 0; q < 2; q++) begin
            qa = q ? cfs_pkg::OFS_RXQ1 : cfs_pkg::OFS_RXQ0;
            bus(1'b1, 1'b0, qa, 32'h20);
            bus(1'b0, 1'b1, qa, 32'h0);
            bus(1'b1, 1'b0, cfs_pkg::OFS_IRQ_MSK, 32'h66);
            if (q) rate1 <= 2'h1;
            else rate0 <= 2'h1;
            repeat (5) bus(1'b0, 1'b1, qa, 32'h0);
            rate0 <= 2'h0;
            rate1 <= 2'h0;
            bus(1'b1, 1'b0, qa, 32'h33);
            repeat (3) begin
                bus(1'b0, 1'b1, qa, 32'h0);
                bus(1'b1, 1'b0, qa, 32'h20);
            end
            bus(1'b0, 1'b1, qa, 32'h0);
            bus(1'b1, 1'b0, qa, 32'h8);
            bus(1'b1, 1'b0, cfs_pkg::OFS_IRQ_MSK, 32'h0);
        end
        for (int i = 0; i < 600; i++) begin
            rate0 <= 2'($urandom_range(2));
            rate1 <= 2'($urandom_range(2));
            if (i == 300) RSTN <= 1'b0;
            if (i == 302) RSTN <= 1'b1;
            k = $urandom_range(6);
            if ($urandom_range(1) == 0) bus(1'b1, 1'b0, adrs[k], k < 2 ? $urandom & 32'h3b : $urandom);
            else bus(1'b0, 1'b1, adrs[k], 32'h0);
        end
        tally_and_finish();
    end
endmodule : tb_top
